// ==== gtc_count_core.v ====
/*
 * Counting core of a 16-bit general timer: prescaler, up/down counter,
 * input filters with polarity and edge detect, four capture/compare
 * channels and a complementary flip output pair.
 * Assumes all control inputs come from software logic on ref_clk; only
 * the trigger and channel pins are asynchronous and are synchronised here.
 * Capture sources are the pins only; interrupt flags and their enables
 * beyond the per-channel request pulse live outside this core, and
 * compare action codes other than the four listed hold the output.
 */
`include "gtc_defines.vh"
`default_nettype none

module gtc_count_core (
    // clock and reset
    input  wire        ref_clk,
    input  wire        rst_b,
    // run control
    input  wire        swRunSet,
    input  wire        swRunClear,
    output reg         runEnable,
    // mode configuration
    input  wire [1:0]  mode,
    input  wire        singleShotSelect,
    input  wire [1:0]  quadratureModeSelect,
    input  wire        countSense,
    input  wire        triggerSourceSelect,
    // prescaler and counter
    input  wire [15:0] prescaleValue,
    input  wire [15:0] reloadValue,
    input  wire        countLoad,
    input  wire [15:0] countLoadValue,
    output reg  [15:0] countValue,
    // counter events
    output reg         wrapPulse,
    output reg         underflowPulse,
    output reg         overflowFlag,
    input  wire        overflowFlagClear,
    // trigger inputs
    input  wire        externalTriggerInput,
    input  wire        internalCascadeTrigger,
    input  wire [3:0]  extTriggerFilterCfg,
    input  wire        extTriggerInvert,
    // channel configuration
    input  wire [3:0]  channelPin,
    input  wire [15:0] channelFilterCfg,
    input  wire [3:0]  channelInvert,
    input  wire [3:0]  channelCompareSelect,
    input  wire [15:0] channelOutputMode,
    input  wire [3:0]  channelIrqEnable,
    input  wire [3:0]  channelValueWrite,
    input  wire [15:0] channelValueData,
    // channel results
    output wire [63:0] channelCaptureValue,
    output wire [3:0]  channelOut,
    output wire [3:0]  channelIrqRequest,
    // edge reports, bit 0 trigger, bits 4:1 channels
    output wire [4:0]  edgeRise,
    output wire [4:0]  edgeFall,
    // flip outputs
    input  wire        flipOutputEnable,
    output wire        flipOutPos,
    output wire        flipOutNeg
);

    // pin synchronisers, index 0 is the trigger pin
    // every pin crosses two flops before any logic looks at it; a pulse
    // shorter than the filter's sample period can slip through unseen
    wire [4:0]  rawIn = {channelPin, externalTriggerInput};
    wire [19:0] cfgAll = {channelFilterCfg, extTriggerFilterCfg};
    wire [4:0]  invAll = {channelInvert, extTriggerInvert};
    reg  [4:0]  syncA;
    reg  [4:0]  syncB;
    reg  [2:0]  sampleDiv;
    wire [4:0]  filtLvl;
    wire [4:0]  polLvl;
    // edges stay quiet until sync and filter hold real pin levels, so an
    // idle-high pin or a preset invert gives no false edge after reset
    reg  [2:0]  armCnt;
    wire        edgeArmed = (armCnt == `GTC_ARM_CYCLES);

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            syncA     <= 5'h00;
            syncB     <= 5'h00;
            sampleDiv <= `GTC_DIV_RESET;
            armCnt    <= `GTC_ARM_RESET;
        end else begin
            syncA     <= rawIn;
            syncB     <= syncA;
            sampleDiv <= sampleDiv + 3'h1;
            if (!edgeArmed) begin
                armCnt <= armCnt + 3'h1;
            end
        end
    end

    genvar i;
    generate
        for (i = 0; i < 5; i = i + 1) begin : g_input
            wire [3:0] cfg = cfgAll[4*i+:4];
            // sample period 1,2,4,8 clocks, run length 1,2,4,8 samples
            // a run length of one sample passes the level straight through
            wire [2:0] rateMask = {cfg[3:2] == 2'h3, cfg[3], cfg[3:2] != 2'h0};
            wire [2:0] runTarget = {cfg[1:0] == 2'h3, cfg[1], cfg[1:0] != 2'h0};
            wire       sampleTick = ((sampleDiv & rateMask) == 3'h0);
            wire       inLvl = syncB[i];
            reg        cand;
            reg  [2:0] runCnt;
            reg        fLvl;
            reg        pLvl;
            reg        rise;
            reg        fall;
            wire       invLvl = fLvl ^ invAll[i];

            assign filtLvl[i]  = fLvl;
            assign polLvl[i]   = pLvl;
            assign edgeRise[i] = rise;
            assign edgeFall[i] = fall;

            always @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    cand   <= 1'b0;
                    runCnt <= `GTC_FLT_CNT_RESET;
                    fLvl   <= 1'b0;
                end else if (!edgeArmed) begin
                    // preload from the pin rather than filter up from zero
                    cand <= inLvl;
                    fLvl <= inLvl;
                end else if (sampleTick) begin // R7
                    if (inLvl != cand) begin // R6
                        cand   <= inLvl;
                        runCnt <= `GTC_FLT_CNT_RESET;
                        if (runTarget == 3'h0)
                            fLvl <= inLvl;
                    end else if (runCnt != runTarget) begin
                        runCnt <= runCnt + 3'h1;
                        if (runCnt + 3'h1 == runTarget)
                            fLvl <= inLvl; // R6
                    end
                end
            end

            // edge reports follow the polarity-corrected level
            always @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    pLvl <= 1'b0;
                    rise <= 1'b0;
                    fall <= 1'b0;
                end else begin
                    pLvl <= invLvl; // R8
                    rise <= edgeArmed & invLvl & ~pLvl; // R9
                    fall <= edgeArmed & ~invLvl & pLvl; // R9
                end
            end
        end
    endgenerate

    // trigger source and count source selection
    // cascade input shares our clock, so it needs no synchroniser
    reg  itrPrev;
    wire itrRise = internalCascadeTrigger & ~itrPrev;
    // invert already applied, so the rising report follows the chosen edge
    wire trigEvent = triggerSourceSelect ? itrRise : edgeRise[0]; // R17 R18
    wire trigSrc = (mode == `GTC_MODE_COUNTER);
    reg  srcEvent;

    // timer and trigger-start count every bus clock through the divider;
    // gated mode holds the divider still while the gate is closed, so a
    // reopened gate resumes mid-period rather than restarting it
    always @* begin
        case (mode) // R15
            `GTC_MODE_TIMER:   srcEvent = 1'b1; // R16
            `GTC_MODE_COUNTER: srcEvent = trigEvent; // R17
            `GTC_MODE_TRIGGER: srcEvent = 1'b1;
            `GTC_MODE_GATED:   srcEvent = polLvl[0];
            default:           srcEvent = 1'b0;
        endcase
    end

    // prescaler as a count strobe, never a derived clock
    // counter mode divides by the value itself, so zero is taken as one
    reg  [15:0] psActive;
    reg  [15:0] psCnt;
    wire [15:0] psLimit = trigSrc ? ((psActive == 16'h0000) ? 16'h0000
                                     : psActive - 16'h0001) // R20
                                  : psActive; // R20
    wire        countTick = runEnable & srcEvent & (psCnt == psLimit); // R23

    // counter step decisions
    // reload is compared live: lowering it below the count lets the count
    // run on to the top before wrapping, so software keeps it above
    wire quadrature_mode_select = (quadratureModeSelect != 2'h0); // R4
    wire atReload = (countValue == reloadValue); // R22
    wire atZero = (countValue == `GTC_COUNT_RESET);
    wire upWrap = countTick & atReload & (~quadrature_mode_select | countSense);
    wire downWrap = countTick & quadrature_mode_select & ~countSense & atZero;
    wire oneShotStop = upWrap & ~quadrature_mode_select & singleShotSelect; // R1
    wire trigStart = (mode == `GTC_MODE_TRIGGER) & trigEvent;
    wire next_runEnable = (runEnable & ~swRunClear & ~oneShotStop)
                          | swRunSet | trigStart;

    // run control; a software set wins over every clear, and in
    // trigger-start mode a trigger edge sets the run bit as well
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            itrPrev   <= 1'b0;
            runEnable <= 1'b0;
        end else begin
            itrPrev   <= internalCascadeTrigger;
            runEnable <= next_runEnable; // R1
        end
    end

    // prescaler shadow and divider
    // shadow loads on wrap so a changed divide starts on a clean period
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            psActive <= `GTC_PS_RESET;
            psCnt    <= `GTC_PS_RESET;
        end else begin
            // stopped: shadow follows, so a start picks up the new value
            if (!runEnable || upWrap) begin
                psActive <= prescaleValue; // R21
            end
            if (!runEnable) begin
                psCnt <= `GTC_PS_RESET;
            end else if (srcEvent) begin
                psCnt <= countTick ? `GTC_PS_RESET : psCnt + 16'h0001; // R20
            end
        end
    end

    // wrap events and the sticky overflow flag
    // pulses last one clock and need no software clear
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrapPulse      <= 1'b0;
            underflowPulse <= 1'b0;
            overflowFlag   <= 1'b0;
        end else begin
            wrapPulse      <= upWrap; // R2
            underflowPulse <= downWrap; // R5
            // a new overflow beats a clear in the same cycle
            if (upWrap & ~quadrature_mode_select & ~singleShotSelect) begin
                overflowFlag <= 1'b1; // R3
            end else if (overflowFlagClear) begin
                overflowFlag <= 1'b0;
            end
        end
    end

    // the count itself; a software load beats a count step
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            countValue <= `GTC_COUNT_RESET;
        end else if (countLoad) begin
            countValue <= countLoadValue;
        end else if (countTick) begin
            if (quadrature_mode_select && !countSense) begin // R4
                countValue <= atZero ? `GTC_COUNT_MAX // R5
                                     : countValue - 16'h0001;
            end else if (atReload) begin
                countValue <= `GTC_COUNT_RESET; // R3 R5 R19
            end else begin
                countValue <= countValue + 16'h0001; // R16 R19
            end
        end
    end

    // capture and compare channels, one register set each
    // capture takes both edges; the edge report already carries polarity
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_chan
            wire [3:0]  outMode = channelOutputMode[4*i+:4];
            wire        isCompare = channelCompareSelect[i];
            wire        capEvent = ~isCompare & (edgeRise[i+1] | edgeFall[i+1]);
            reg  [15:0] ccValue;
            reg         matchPrev;
            reg         outLvl;
            reg         irqReq;
            wire        match = (countValue == ccValue); // R11
            wire        matchEvent = isCompare & match & ~matchPrev;

            assign channelCaptureValue[16*i+:16] = ccValue;
            assign channelOut[i]                 = outLvl;
            assign channelIrqRequest[i]          = irqReq;

            always @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    ccValue   <= `GTC_COUNT_RESET;
                    matchPrev <= 1'b0;
                    outLvl    <= 1'b0;
                    irqReq    <= 1'b0;
                end else begin
                    matchPrev <= match;
                    // capture beats a software write in the same cycle
                    if (capEvent) begin
                        ccValue <= countValue; // R10
                    end else if (channelValueWrite[i]) begin
                        ccValue <= channelValueData;
                    end
                    if (isCompare) begin
                        case (outMode) // R12
                            `GTC_OUT_FORCE_LOW:  outLvl <= 1'b0;
                            `GTC_OUT_FORCE_HIGH: outLvl <= 1'b1;
                            `GTC_OUT_MATCH_LOW:
                                if (matchEvent) outLvl <= 1'b0; // R11
                            `GTC_OUT_MATCH_HIGH:
                                if (matchEvent) outLvl <= 1'b1; // R11
                            default: outLvl <= outLvl;
                        endcase
                    end
                    // request is a one-clock pulse; flags live outside
                    irqReq <= channelIrqEnable[i] & (capEvent | matchEvent); // R10 R11
                end
            end
        end
    endgenerate

    // flip output pair
    // the pair leaves reset and disable with the positive pin high, and
    // both pins are gated by the enable so a disabled pair rests low
    reg flipState;

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            flipState <= 1'b1;
        end else if (!flipOutputEnable) begin
            flipState <= 1'b1; // R14
        end else if (wrapPulse) begin
            flipState <= ~flipState; // R14
        end
    end

    assign flipOutPos = flipOutputEnable & flipState; // R13 R14
    assign flipOutNeg = flipOutputEnable & ~flipState; // R13 R14

endmodule

`default_nettype wire

// ==== gtc_count_core_bench.sv ====
/* self-checking bench for gtc_count_core.
   assumes the pin model drives the trigger and channel lines. */
`include "gtc_defines.vh"
`default_nettype none
module gtc_count_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0, rst_b = 1'b0, swRunSet = 1'b0, swRunClear = 1'b0;
    logic        singleShotSelect = 1'b0, countSense = 1'b0, countLoad = 1'b0, slow = 1'b0;
    logic        triggerSourceSelect = 1'b0, extTriggerInvert = 1'b0, flipOutputEnable = 1'b0;
    logic        overflowFlagClear = 1'b0, trigLevel = 1'b0, cascadeLevel = 1'b0, fp;
    logic [1:0]  mode = 2'h0, quadratureModeSelect = 2'h0;
    logic [3:0]  chanLevel = 4'h0, channelInvert = 4'h0, channelCompareSelect = 4'h2;
    logic [3:0]  channelIrqEnable = 4'h1, channelValueWrite = 4'h0, extTriggerFilterCfg = 4'h0;
    logic [15:0] prescaleValue = 16'h0000, reloadValue = 16'h0000, countLoadValue = 16'h0000;
    logic [15:0] channelFilterCfg = 16'h0000, channelOutputMode = 16'h0000;
    logic [15:0] channelValueData = 16'h0003, countValue;
    logic        runEnable, wrapPulse, underflowPulse, overflowFlag, flipOutPos, flipOutNeg;
    logic        externalTriggerInput, internalCascadeTrigger;
    logic [3:0]  channelPin, channelOut, channelIrqRequest;
    logic [4:0]  edgeRise, edgeFall;
    logic [63:0] channelCaptureValue;
    logic [3:0]  md [4] = '{`GTC_OUT_FORCE_HIGH, `GTC_OUT_FORCE_LOW, `GTC_OUT_MATCH_HIGH,
                            `GTC_OUT_MATCH_LOW};
    int          err_count = 0, tests_run = 0, n;
    gtc_count_core dut_u (.*);
    gtc_pin_model pm_u (.*);
    always #20 ref_clk = ~ref_clk;
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic cyc(int k);
        repeat (k) @(negedge ref_clk);
    endtask
    // pulses are looked at on falling edges, half a cycle after they land
    task automatic waitHi(int s, output int k);
        k = 0;
        while ((s == 0 ? wrapPulse : s == 1 ? underflowPulse : edgeFall[1]) !== 1'b1) begin
            cyc(1);
            k++;
            if (k > 400) begin
                check("wait bound", 16'h0000, 16'h0001);
                complete_run();
            end
        end
    endtask
    task automatic load(logic [15:0] v);
        cyc(1);
        swRunClear = 1'b1;
        countLoad = 1'b1;
        countLoadValue = v;
        cyc(1);
        swRunClear = 1'b0;
        countLoad = 1'b0;
    endtask
    task automatic setup(logic [1:0] m, logic [15:0] p, logic [15:0] r);
        mode = m;
        prescaleValue = p;
        reloadValue = r;
        load(16'h0000);
        swRunSet = 1'b1;
        cyc(1);
        swRunSet = 1'b0;
    endtask
    task automatic t_timer();
        flipOutputEnable = 1'b1;
        setup(`GTC_MODE_TIMER, 16'h0001, 16'h0003);
        waitHi(0, n);
        cyc(2);
        fp = flipOutPos;
        waitHi(0, n);
        check("wrap period", 16'h0008, 16'(n + 2));
        check("overflow flag", 16'h0001, {15'h0, overflowFlag});
        overflowFlagClear = 1'b1;
        cyc(1);
        overflowFlagClear = 1'b0;
        check("flag clear", 16'h0000, {15'h0, overflowFlag});
        cyc(2);
        check("flip pos", {15'h0, ~fp}, {15'h0, flipOutPos});
        check("flip neg", {15'h0, fp}, {15'h0, flipOutNeg});
        flipOutputEnable = 1'b0;
        cyc(1);
        check("flip off", 16'h0000, {14'h0, flipOutPos, flipOutNeg});
        singleShotSelect = 1'b1;
        setup(`GTC_MODE_TIMER, 16'h0000, 16'h0005);
        waitHi(0, n);
        cyc(2);
        check("single run bit", 16'h0000, {15'h0, runEnable});
        check("single count", 16'h0000, countValue);
        singleShotSelect = 1'b0;
        $display("timer and single shot done");
    endtask
    task automatic t_encoder();
        quadratureModeSelect = 2'h1;
        countSense = 1'b1;
        setup(`GTC_MODE_TIMER, 16'h0000, 16'h0004);
        waitHi(0, n);
        check("up wrap count", 16'h0000, countValue);
        countSense = 1'b0;
        waitHi(1, n);
        check("down step delay", 16'h0001, 16'(n));
        check("down wrap count", 16'hFFFF, countValue);
        quadratureModeSelect = 2'h0;
        load(16'h0000);
        $display("encoder done");
    endtask
    task automatic t_counter();
        for (int k = 0; k < 3; k++) begin
            triggerSourceSelect = (k == 2);
            extTriggerInvert = (k == 1);
            cyc(10);
            setup(`GTC_MODE_COUNTER, 16'h0001, 16'h0002);
            // three rises and two falls; inverted counts falls only
            repeat (5) begin
                if (k == 2)
                    cascadeLevel = ~cascadeLevel;
                else
                    trigLevel = ~trigLevel;
                cyc(10);
            end
            check("event count", (k == 1) ? 16'h0002 : 16'h0000, countValue);
            trigLevel = 1'b0;
            cascadeLevel = 1'b0;
        end
        extTriggerInvert = 1'b0;
        $display("counter mode done");
    endtask
    task automatic t_capture();
        channelInvert = 4'h1;
        slow = 1'b1;
        cyc(10);
        load(16'h1234);
        chanLevel = 4'h1;
        waitHi(2, n);
        check("no rise report", 16'h0000, {15'h0, edgeRise[1]});
        cyc(1);
        check("capture irq", 16'h0001, {15'h0, channelIrqRequest[0]});
        cyc(1);
        check("capture", 16'h1234, channelCaptureValue[15:0]);
        channelFilterCfg = 16'h0003;
        load(16'h0055);
        chanLevel = 4'h0;
        cyc(3);
        chanLevel = 4'h1;
        cyc(20);
        check("glitch kept out", 16'h1234, channelCaptureValue[15:0]);
        chanLevel = 4'h0;
        cyc(20);
        check("long pulse taken", 16'h0055, channelCaptureValue[15:0]);
        $display("capture done");
    endtask
    task automatic t_compare();
        channelValueWrite = 4'h2;
        cyc(1);
        channelValueWrite = 4'h0;
        setup(`GTC_MODE_TIMER, 16'h0000, 16'h0007);
        for (int i = 0; i < 4; i++) begin
            channelOutputMode[7:4] = md[i];
            n = 0;
            while (channelOut[1] !== ~i[0] && n < 30) begin
                cyc(1);
                n++;
            end
            check("channel out", {15'h0, ~i[0]}, {15'h0, channelOut[1]});
        end
        $display("compare done");
    endtask
    task automatic t_modes();
        triggerSourceSelect = 1'b0;
        setup(`GTC_MODE_GATED, 16'h0000, 16'h00FF);
        cyc(10);
        check("gate closed", 16'h0000, countValue);
        trigLevel = 1'b1;
        cyc(10);
        trigLevel = 1'b0;
        cyc(12);
        check("gate open count", 16'h000A, countValue);
        mode = `GTC_MODE_TRIGGER;
        load(16'h0000);
        check("trigger idle", 16'h0000, {15'h0, runEnable});
        trigLevel = 1'b1;
        cyc(12);
        check("trigger start", 16'h0001, {15'h0, runEnable});
        trigLevel = 1'b0;
        $display("gated and trigger start done");
    endtask
    initial begin
        cyc(4);
        rst_b = 1'b1;
        t_timer();
        t_encoder();
        t_counter();
        t_capture();
        t_modes();
        t_compare();
        complete_run();
    end
endmodule
`default_nettype wire

// ==== gtc_count_core_props.sv ====
/* checker for gtc_count_core: wrap, single shot, encoder, flip pair, capture.
   assumes one clock ref_clk and asynchronous active-low rst_b. */
`default_nettype none
module gtc_count_core_props (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_b,
    // control
    input wire logic        swRunSet,
    input wire logic        singleShotSelect,
    input wire logic [1:0]  quadratureModeSelect,
    input wire logic        countSense,
    input wire logic        countLoad,
    input wire logic [3:0]  channelCompareSelect,
    input wire logic        flipOutputEnable,
    // observed
    input wire logic        runEnable,
    input wire logic [15:0] countValue,
    input wire logic        wrapPulse,
    input wire logic        underflowPulse,
    input wire logic        overflowFlag,
    input wire logic [63:0] channelCaptureValue,
    input wire logic [4:0]  edgeRise,
    input wire logic [4:0]  edgeFall,
    input wire logic        flipOutPos,
    input wire logic        flipOutNeg
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_flipWrap;
        flipOutputEnable && $past(flipOutputEnable) && wrapPulse;
    endsequence
    sequence s_captureEdge;
        (edgeRise[1] || edgeFall[1]) && !channelCompareSelect[0];
    endsequence
    a_wrap_one_cycle: assert property (wrapPulse |=> !wrapPulse)
        else $error("wrap pulse longer than one cycle");
    a_single_shot_halts: assert property ($rose(wrapPulse) && singleShotSelect
        && quadratureModeSelect == 2'h0 && !$past(swRunSet) && !$past(countLoad)
        |-> !runEnable && countValue == 16'h0000) else $error("single shot did not halt");
    a_cont_flag_set: assert property (wrapPulse && !singleShotSelect
        && quadratureModeSelect == 2'h0 |-> overflowFlag) else $error("overflow flag not set");
    a_flip_off_low: assert property (!flipOutputEnable |-> !flipOutPos && !flipOutNeg)
        else $error("flip outputs not low");
    a_flip_wrap_toggle: assert property (s_flipWrap ##1 flipOutputEnable [*2]
        |-> flipOutPos != $past(flipOutPos, 3) && flipOutNeg != flipOutPos)
        else $error("flip pair did not toggle");
    a_encoder_step_dir: assert property ($past(quadratureModeSelect != 2'h0 && !countLoad)
        && $changed(countValue) |-> ($past(countSense) && (countValue == 16'h0000
        || countValue == 16'($past(countValue) + 16'h0001))) || (!$past(countSense)
        && countValue == 16'($past(countValue) - 16'h0001))) else $error("encoder step wrong");
    a_underflow_max: assert property (underflowPulse && !$past(countLoad)
        |-> countValue == 16'hFFFF) else $error("underflow count not FFFF");
    a_capture_copies: assert property (s_captureEdge
        |=> channelCaptureValue[15:0] == $past(countValue)) else $error("capture value wrong");
endmodule
bind gtc_count_core gtc_count_core_props chk_u (.*);
`default_nettype wire

// ==== gtc_defines.vh ====
/*
 * Constants for the general timer counting core: operating mode codes,
 * compare output action codes, count limits and reset values.
 * Assumes the includer wants plain text macros only; no logic lives here.
 */
//
// Functional notes
// R1: single shot: wrap pulse, halt, clear run
// R2: wrap pulse lasts exactly one clock
// R3: continuous: roll to zero sets overflow flag
// R4: encoder mode: direction from count sense input
// R5: encoder wraps up to zero, down to max
// R6: filter accepts level after N equal samples
// R7: each filter has own rate and count
// R8: optional inversion of trigger and channels
// R9: edge detect reports rising or falling
// R10: capture copies count, optional interrupt request
// R11: compare match drives output, optional interrupt
// R12: per channel output mode picks match action
// R13: flip disabled: both flip outputs low
// R14: flip enabled: opposite levels, toggle on wrap
// R15: mode field selects timer/counter/trigger/gated
// R16: timer mode counts prescaled bus clock ticks
// R17: counter source select: trigger pin or cascade
// R18: invert picks counting edge of trigger pin
// R19: counter mode advances, wraps to zero
// R20: divide by value+1 bus, value trigger
// R21: new prescale applies at wrap or start
// R22: reload value change takes effect immediately
// R23: single clock domain, count enable strobes
`ifndef GTC_DEFINES_VH
`define GTC_DEFINES_VH

`define GTC_MODE_TIMER    2'h0
`define GTC_MODE_COUNTER  2'h1
`define GTC_MODE_TRIGGER  2'h2
`define GTC_MODE_GATED    2'h3

`define GTC_OUT_FORCE_LOW  4'h8
`define GTC_OUT_FORCE_HIGH 4'h9
`define GTC_OUT_MATCH_LOW  4'hA
`define GTC_OUT_MATCH_HIGH 4'hB

`define GTC_COUNT_MAX      16'hFFFF
`define GTC_COUNT_RESET    16'h0000
`define GTC_FLT_CNT_RESET  3'h0
`define GTC_DIV_RESET      3'h0
`define GTC_PS_RESET       16'h0000
`define GTC_ARM_RESET      3'h0
`define GTC_ARM_CYCLES     3'h4

`endif

// ==== gtc_pin_model.sv ====
/* partner for the timer pins: trigger, cascade and channel lines.
   assumes the bench commands levels; slow adds two cycles of pin lag. */
`default_nettype none
module gtc_pin_model (
    // clock and commands
    input  wire logic       ref_clk,
    input  wire logic       slow,
    input  wire logic       trigLevel,
    input  wire logic       cascadeLevel,
    input  wire logic [3:0] chanLevel,
    // lines toward the timer
    output var  logic       externalTriggerInput,
    output var  logic       internalCascadeTrigger,
    output var  logic [3:0] channelPin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] stage [0:2] = '{6'h00, 6'h00, 6'h00};
    // cascade comes from a timer on the same clock, so it only moves on edges
    always @(posedge ref_clk) begin
        stage[0] <= {trigLevel, cascadeLevel, chanLevel};
        stage[1] <= stage[0];
        stage[2] <= stage[1];
    end
    assign {externalTriggerInput, internalCascadeTrigger, channelPin} = slow ? stage[2] : stage[0];
endmodule
`default_nettype wire
